// ==== hdl/integrating_channel.sv ====
`timescale 1ns/1ps
module integrating_channel
  import light_sensor_pkg::*;
#(
  parameter int WIDTH = MAX_RES_BITS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic active,
  input wire logic light_pulse,
  input wire logic [WIDTH-1:0] full_scale,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] next_count;

  // saturating photon accumulator
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (active && light_pulse && (count < full_scale)) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ==== hdl/light_sensor_pkg.sv ====
// Function
// - enabled channels integrate together; ambient mode enables green and IR only
// - results move to data registers at end
// - two-wire host link up to 400 kHz
// - enabled and limit passed raises interrupt pin
// - interrupt held until host clears it or drops the interrupt enable
// - check once per conversion, one chosen channel
// - consecutive exceed count; miss restarts count
// - ambient only or full colour configuration
// - results up to twenty bits, selectable
// - eighteen bit result saturates at 262143
// - thirteen bit step spans 8192 counts
// - mode bit: 0 ambient, 1 colour
// - disable finishes running conversion, then standby
// - variance: absolute change above variance threshold
// - answer only target address 0x52
package light_sensor_pkg;

  localparam int MAX_RES_BITS = 20;
  localparam int CHANNELS = 4;

  // host link target address
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h52;

  // resolution select codes
  localparam logic [2:0] RES_20 = 3'h0;
  localparam logic [2:0] RES_19 = 3'h1;
  localparam logic [2:0] RES_18 = 3'h2;
  localparam logic [2:0] RES_17 = 3'h3;
  localparam logic [2:0] RES_16 = 3'h4;
  localparam logic [2:0] RES_13 = 3'h5;

  // result widths per code
  localparam logic [4:0] WIDTH_20 = 5'h14;
  localparam logic [4:0] WIDTH_19 = 5'h13;
  localparam logic [4:0] WIDTH_18 = 5'h12;
  localparam logic [4:0] WIDTH_17 = 5'h11;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_13 = 5'h0D;

  // channel indices
  localparam logic [1:0] CH_RED = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE = 2'h2;
  localparam logic [1:0] CH_IR = 2'h3;

  // channel masks per configuration
  localparam logic [3:0] MASK_COLOUR = 4'hF;
  localparam logic [3:0] MASK_AMBIENT = 4'hA;

  // reset values
  localparam logic [19:0] DATA_RESET = 20'h00000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // result width from resolution code; unknown codes fall back to 18 bits
  function automatic logic [4:0] res_width(input logic [2:0] code);
    case (code)
      RES_20: res_width = WIDTH_20;
      RES_19: res_width = WIDTH_19;
      RES_18: res_width = WIDTH_18;
      RES_17: res_width = WIDTH_17;
      RES_16: res_width = WIDTH_16;
      RES_13: res_width = WIDTH_13;
      default: res_width = WIDTH_18;
    endcase
  endfunction

  typedef enum logic [2:0] {
    M_STANDBY = 3'b001,
    M_INTEGRATE = 3'b010,
    M_EVALUATE = 3'b100
  } meas_state_type;

  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_ADDR = 5'b00010,
    I_ACK = 5'b00100,
    I_WRITE = 5'b01000,
    I_READ = 5'b10000
  } link_state_type;

endpackage

// ==== hdl/rgb_ir_light_sensor_readout.sv ====
`timescale 1ns/1ps
module rgb_ir_light_sensor_readout
  import light_sensor_pkg::*;
#(
  parameter int unsigned INT_STEP_CYCLES = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic light_measure_enable,
  input wire logic color_sensing_mode,
  input wire logic [2:0] resolution_select,
  input wire logic light_irq_enable,
  input wire logic variance_trigger_select,
  input wire logic [1:0] irq_source_channel,
  input wire logic [3:0] irq_persist,
  input wire logic [19:0] threshold_upper,
  input wire logic [19:0] threshold_lower,
  input wire logic [19:0] variance_threshold,
  input wire logic irq_clear,
  input wire logic [3:0] light_pulse,
  output logic [19:0] red_data,
  output logic [19:0] green_data,
  output logic [19:0] blue_data,
  output logic [19:0] ir_data,
  output logic conversion_done,
  output logic measuring,
  output logic irq_pending,
  output logic int_pin_out,
  output logic int_pin_oe,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] host_rx_byte,
  output logic host_rx_valid,
  input wire logic [7:0] host_tx_byte,
  output logic host_tx_taken
);

  meas_state_type state, next_state;
  logic [31:0] step_count, next_step_count;
  logic [4:0] width, next_width;
  logic [19:0] full_scale;
  logic [31:0] conv_len;
  logic [3:0] channel_mask, next_channel_mask;
  logic [19:0] counts [CHANNELS];
  logic channel_clear;
  logic [19:0] next_red, next_green, next_blue, next_ir;
  logic next_done;

  // conversion length and full scale follow the latched width
  assign full_scale = 20'((21'h000001 << width) - 21'h000001);
  assign conv_len = (32'h00000001 << width) * 32'(INT_STEP_CYCLES);
  assign channel_clear = (state != M_INTEGRATE);

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    integrating_channel #(
      .WIDTH(MAX_RES_BITS)
    ) i_integrating_channel (
      .clk(clk),
      .reset(reset),
      .clear(channel_clear),
      .active((state == M_INTEGRATE) && channel_mask[ch]),
      .light_pulse(light_pulse[ch]),
      .full_scale(full_scale),
      .count(counts[ch])
    );
  end

  // measurement sequencer
  always_comb begin
    next_state = state;
    next_step_count = step_count;
    next_width = width;
    next_channel_mask = channel_mask;
    next_red = red_data;
    next_green = green_data;
    next_blue = blue_data;
    next_ir = ir_data;
    next_done = 1'b0;
    case (state)
      M_STANDBY: begin
        if (light_measure_enable) begin
          next_state = M_INTEGRATE;
          next_step_count = 32'h00000000;
          next_width = res_width(resolution_select);
          next_channel_mask = color_sensing_mode ? MASK_COLOUR : MASK_AMBIENT;
        end
      end
      M_INTEGRATE: begin
        if (step_count == conv_len - 32'h00000001) begin
          next_state = M_EVALUATE;
        end else begin
          next_step_count = step_count + 32'h00000001;
        end
      end
      M_EVALUATE: begin
        next_red = counts[CH_RED];
        next_green = counts[CH_GREEN];
        next_blue = counts[CH_BLUE];
        next_ir = counts[CH_IR];
        next_done = 1'b1;
        next_step_count = 32'h00000000;
        next_width = res_width(resolution_select);
        next_channel_mask = color_sensing_mode ? MASK_COLOUR : MASK_AMBIENT;
        next_state = light_measure_enable ? M_INTEGRATE : M_STANDBY;
      end
      default: next_state = M_STANDBY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= M_STANDBY;
      step_count <= 32'h00000000;
      width <= WIDTH_18;
      channel_mask <= MASK_COLOUR;
      red_data <= DATA_RESET;
      green_data <= DATA_RESET;
      blue_data <= DATA_RESET;
      ir_data <= DATA_RESET;
      conversion_done <= 1'b0;
    end else begin
      state <= next_state;
      step_count <= next_step_count;
      width <= next_width;
      channel_mask <= next_channel_mask;
      red_data <= next_red;
      green_data <= next_green;
      blue_data <= next_blue;
      ir_data <= next_ir;
      conversion_done <= next_done;
    end
  end

  assign measuring = (state != M_STANDBY);

  // interrupt evaluation state
  logic [19:0] prev_sample, next_prev_sample, sample, delta;
  logic prev_valid, next_prev_valid;
  logic [4:0] exceed_count, next_exceed_count;
  logic next_irq_pending, exceed, set_irq;

  assign sample = counts[irq_source_channel];
  assign delta = (sample > prev_sample) ? (sample - prev_sample) : (prev_sample - sample);

  always_comb begin
    exceed = 1'b0;
    set_irq = 1'b0;
    next_exceed_count = exceed_count;
    next_prev_sample = prev_sample;
    next_prev_valid = prev_valid;
    if (variance_trigger_select) begin
      exceed = prev_valid && (delta > variance_threshold);
    end else begin
      exceed = (sample > threshold_upper) || (sample < threshold_lower);
    end
    if (state == M_EVALUATE) begin
      next_prev_sample = sample;
      next_prev_valid = 1'b1;
    end
    if (!light_irq_enable) begin
      // evaluation off, count held at zero
      next_exceed_count = 5'h00;
    end else if (state == M_EVALUATE) begin
      if (exceed) begin
        if (exceed_count != 5'h1F) begin
          next_exceed_count = exceed_count + 5'h01;
        end
        // compare the count before the increment; the 5'h1F check keeps a saturated count from wrapping
        set_irq = exceed_count >= {1'b0, irq_persist};
      end else begin
        next_exceed_count = 5'h00;
      end
    end
    // held until cleared or interrupt enable drops; set beats clear
    next_irq_pending = light_irq_enable && (set_irq || (irq_pending && !irq_clear));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_sample <= DATA_RESET;
      prev_valid <= 1'b0;
      exceed_count <= 5'h00;
      irq_pending <= 1'b0;
    end else begin
      prev_sample <= next_prev_sample;
      prev_valid <= next_prev_valid;
      exceed_count <= next_exceed_count;
      irq_pending <= next_irq_pending;
    end
  end

  // open drain pull low while pending
  assign int_pin_out = 1'b0;
  assign int_pin_oe = irq_pending;

  // host link pin synchronisers
  logic [2:0] scl_sync, sda_sync;
  logic scl_level, sda_level, scl_new, sda_new;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_level <= 1'b1;
      sda_level <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_level <= scl_new;
      sda_level <= sda_new;
    end
  end

  // oversampled edges, ample margin at 400 kHz
  assign scl_new = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_level;
  assign sda_new = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_level;

  link_state_type link_state, next_link_state;
  logic [3:0] bit_count, next_bit_count;
  logic [7:0] shift, next_shift, next_rx_byte;
  logic read_dir, next_read_dir, drive_low, next_drive_low;
  logic next_rx_valid, next_tx_taken;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = !scl_level && scl_new;
  assign scl_fall = scl_level && !scl_new;
  assign start_cond = scl_level && scl_new && sda_level && !sda_new;
  assign stop_cond = scl_level && scl_new && !sda_level && sda_new;

  // target side byte engine
  always_comb begin
    next_link_state = link_state;
    next_bit_count = bit_count;
    next_shift = shift;
    next_read_dir = read_dir;
    next_drive_low = drive_low;
    next_rx_byte = host_rx_byte;
    next_rx_valid = 1'b0;
    next_tx_taken = 1'b0;
    if (stop_cond) begin
      next_link_state = I_IDLE;
      next_drive_low = 1'b0;
    end else if (start_cond) begin
      next_link_state = I_ADDR;
      next_bit_count = 4'h0;
      next_drive_low = 1'b0;
    end else begin
      case (link_state)
        I_IDLE: next_drive_low = 1'b0;
        I_ADDR, I_WRITE: begin
          if (scl_rise && bit_count != 4'h8) begin
            next_shift = {shift[6:0], sda_new};
            next_bit_count = bit_count + 4'h1;
          end else if (scl_fall && bit_count == 4'h8) begin
            if (link_state == I_WRITE) begin
              next_rx_byte = shift;
              next_rx_valid = 1'b1;
              next_link_state = I_ACK;
              next_drive_low = 1'b1;
            end else if (shift[7:1] == I2C_TARGET_ADDR) begin
              next_read_dir = shift[0];
              next_link_state = I_ACK;
              next_drive_low = 1'b1;
            end else begin
              next_link_state = I_IDLE;
            end
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            next_bit_count = 4'h0;
            if (read_dir) begin
              next_link_state = I_READ;
              next_shift = host_tx_byte;
              next_drive_low = !host_tx_byte[7];
              next_tx_taken = 1'b1;
            end else begin
              next_link_state = I_WRITE;
              next_drive_low = 1'b0;
            end
          end
        end
        I_READ: begin
          if (scl_fall && bit_count < 4'h7) begin
            next_shift = {shift[6:0], 1'b0};
            next_drive_low = !shift[6];
            next_bit_count = bit_count + 4'h1;
          end else if (scl_fall && bit_count == 4'h7) begin
            next_drive_low = 1'b0;
            next_bit_count = 4'h8;
          end else if (scl_rise && bit_count == 4'h8) begin
            // high at acknowledge slot ends the read
            if (sda_new) begin
              next_link_state = I_IDLE;
            end else begin
              next_bit_count = 4'h9;
            end
          end else if (scl_fall && bit_count == 4'h9) begin
            next_shift = host_tx_byte;
            next_drive_low = !host_tx_byte[7];
            next_bit_count = 4'h0;
            next_tx_taken = 1'b1;
          end
        end
        default: next_link_state = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_state <= I_IDLE;
      bit_count <= 4'h0;
      shift <= BYTE_RESET;
      read_dir <= 1'b0;
      drive_low <= 1'b0;
      host_rx_byte <= BYTE_RESET;
      host_rx_valid <= 1'b0;
      host_tx_taken <= 1'b0;
    end else begin
      link_state <= next_link_state;
      bit_count <= next_bit_count;
      shift <= next_shift;
      read_dir <= next_read_dir;
      drive_low <= next_drive_low;
      host_rx_byte <= next_rx_byte;
      host_rx_valid <= next_rx_valid;
      host_tx_taken <= next_tx_taken;
    end
  end

  // data pin is open drain too
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

endmodule

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  output logic scl,
  output logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic drive_low = 1'b0;

  // open-drain data line with pull-up
  assign sda_in = !(drive_low || (sda_oe && !sda_out));

  // clock idles high outside frames
  initial scl = 1'b1;

  task automatic put_bit(input logic b);
    drive_low = !b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
    #40;
  endtask

  // byte msb first, ninth clock samples acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    drive_low = 1'b0;
    #40 scl = 1'b1;
    #40 ack = !sda_in;
    #40 scl = 1'b0;
    #40;
  endtask

  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic ack_a, output logic ack_d);
    drive_low = 1'b0;
    scl = 1'b1;
    #80 drive_low = 1'b1;
    #80 scl = 1'b0;
    #40;
    send_byte(a, ack_a);
    ack_d = 1'b0;
    if (ack_a) send_byte(d, ack_d);
    drive_low = 1'b1;
    #40 scl = 1'b1;
    #80 drive_low = 1'b0;
    #80;
  endtask

  // read one byte, then not-acknowledge and stop
  task automatic rd(input logic [7:0] a, output logic ack_a, output logic [7:0] d);
    drive_low = 1'b0;
    scl = 1'b1;
    #80 drive_low = 1'b1;
    #80 scl = 1'b0;
    #40;
    send_byte(a, ack_a);
    d = 8'h00;
    drive_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #40 scl = 1'b1;
      #40 d[i] = sda_in;
      #40 scl = 1'b0;
      #40;
    end
    // high at ninth clock ends the read
    put_bit(1'b1);
    drive_low = 1'b1;
    #40 scl = 1'b1;
    #80 drive_low = 1'b0;
    #80;
  endtask
endmodule

// ==== verif/sensor_chk.sv ====
`timescale 1ns/1ps
module sensor_chk
  import light_sensor_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic light_irq_enable,
  input wire logic irq_clear,
  input wire logic [2:0] resolution_select,
  input wire logic [19:0] red_data,
  input wire logic [19:0] green_data,
  input wire logic [19:0] blue_data,
  input wire logic [19:0] ir_data,
  input wire logic conversion_done,
  input wire logic measuring,
  input wire logic irq_pending,
  input wire logic int_pin_out,
  input wire logic int_pin_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // result hand-over pulse, then quiet
  sequence s_handover;
    conversion_done ##1 !conversion_done;
  endsequence

  chk_done_single: assert property (conversion_done |-> s_handover)
    else $error("done pulse too long");
  chk_data_on_done: assert property (
    $changed({red_data, green_data, blue_data, ir_data}) |-> conversion_done)
    else $error("data moved without done");
  chk_stop_at_end: assert property ($fell(measuring) |-> conversion_done)
    else $error("stopped before conversion end");
  chk_irq_on_done: assert property ($rose(irq_pending) |-> conversion_done)
    else $error("interrupt outside evaluation");
  chk_irq_held: assert property (irq_pending && light_irq_enable && !irq_clear |=> irq_pending)
    else $error("interrupt dropped uncleared");
  chk_irq_cleared: assert property (irq_clear && !measuring |=> !irq_pending)
    else $error("clear ignored");
  chk_irq_disabled: assert property (!light_irq_enable |=> !irq_pending)
    else $error("interrupt while disabled");
  chk_pin_drain: assert property (int_pin_oe == irq_pending && int_pin_out == 1'b0)
    else $error("interrupt pin drive wrong");
  chk_res13_range: assert property (
    conversion_done && resolution_select == RES_13
    |-> !(|{red_data[19:13], green_data[19:13], blue_data[19:13], ir_data[19:13]}))
    else $error("result above 13 bits");
endmodule

bind rgb_ir_light_sensor_readout sensor_chk i_sensor_chk (.clk, .reset, .light_irq_enable, .irq_clear,
  .resolution_select, .red_data, .green_data, .blue_data, .ir_data, .conversion_done, .measuring,
  .irq_pending, .int_pin_out, .int_pin_oe);

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import light_sensor_pkg::*;
  logic clk, reset, light_measure_enable, color_sensing_mode, light_irq_enable;
  logic variance_trigger_select, irq_clear, scl_in, sda_in, conversion_done, measuring;
  logic irq_pending, int_pin_out, int_pin_oe, sda_out, sda_oe, host_rx_valid, host_tx_taken;
  logic [1:0] irq_source_channel;
  logic [2:0] resolution_select;
  logic [3:0] irq_persist, light_pulse;
  logic [7:0] host_rx_byte, host_tx_byte;
  logic [7:0] rx_last = 8'h00;
  logic [19:0] threshold_upper, threshold_lower, variance_threshold;
  logic [19:0] red_data, green_data, blue_data, ir_data;
  logic ack_a, ack_d;
  logic [7:0] rd_byte;
  int tx_cnt = 0;
  int error_cnt = 0;
  int comparisons = 0;
  int rx_cnt = 0;
  localparam logic [19:0] FULL = 20'h01FFF;

  rgb_ir_light_sensor_readout #(.INT_STEP_CYCLES(1)) i_rgb_ir_light_sensor_readout (
    .clk, .reset, .light_measure_enable, .color_sensing_mode, .resolution_select,
    .light_irq_enable, .variance_trigger_select, .irq_source_channel, .irq_persist,
    .threshold_upper, .threshold_lower, .variance_threshold, .irq_clear, .light_pulse,
    .red_data, .green_data, .blue_data, .ir_data, .conversion_done, .measuring,
    .irq_pending, .int_pin_out, .int_pin_oe, .scl_in, .sda_in, .sda_out, .sda_oe,
    .host_rx_byte, .host_rx_valid, .host_tx_byte, .host_tx_taken);
  host_model i_host_model (.scl(scl_in), .sda_in, .sda_out, .sda_oe);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // bytes written and read over the link
  always @(posedge clk) begin
    if (host_rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
      rx_last <= host_rx_byte;
    end
    if (host_tx_taken === 1'b1) begin
      tx_cnt <= tx_cnt + 1;
    end
  end

  task automatic stop_test();
    $display("counts: %0d mismatches, %0d compares", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic dat(input logic [19:0] r, input logic [19:0] g, input logic [19:0] b, input logic [19:0] i);
    cmp(red_data, r, "red");
    cmp(green_data, g, "green");
    cmp(blue_data, b, "blue");
    cmp(ir_data, i, "ir");
  endtask

  // one conversion, enable dropped while it runs
  task automatic conv(input logic [3:0] p);
    int k;
    k = 0;
    light_pulse = p;
    cmp(20'(measuring), 20'h0, "idle");
    light_measure_enable = 1'b1;
    @(negedge clk);
    light_measure_enable = 1'b0;
    @(negedge clk);
    cmp(20'(measuring), 20'h1, "busy");
    while (conversion_done !== 1'b1 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 9000) begin
      error_cnt++;
      $display("BAD %0t no done", $time);
      stop_test();
    end
  endtask

  task automatic t_link();
    i_host_model.xfer(8'hA4, 8'h3C, ack_a, ack_d);
    cmp(20'(ack_a), 20'h1, "own address");
    cmp(20'(ack_d), 20'h1, "data ack");
    cmp(20'(rx_last), 20'h3C, "byte");
    i_host_model.xfer(8'hA6, 8'h5A, ack_a, ack_d);
    cmp(20'(ack_a), 20'h0, "other address");
    cmp(20'(rx_cnt), 20'h1, "byte count");
    @(negedge clk);
    host_tx_byte = 8'hC5;
    i_host_model.rd(8'hA5, ack_a, rd_byte);
    cmp(20'(ack_a), 20'h1, "read address");
    cmp(20'(rd_byte), 20'hC5, "read byte");
    cmp(20'(tx_cnt), 20'h1, "read taken");
    cmp(20'(rx_cnt), 20'h1, "no write on read");
    $display("test link done");
  endtask

  task automatic t_ambient();
    logic [1:0] ch;
    color_sensing_mode = 1'b0;
    for (int c = 0; c < 4; c++) begin
      ch = 2'(c);
      irq_source_channel = ch;
      conv(4'hF);
      dat(20'h0, FULL, 20'h0, FULL);
      cmp(20'(irq_pending), 20'(ch[0]), "pending");
      cmp(20'(int_pin_oe), 20'(ch[0]), "pin");
      irq_clear = 1'b1;
      @(negedge clk);
      irq_clear = 1'b0;
      cmp(20'(irq_pending), 20'h0, "cleared");
    end
    $display("test ambient done");
  endtask

  task automatic t_persist();
    color_sensing_mode = 1'b1;
    irq_source_channel = CH_GREEN;
    irq_persist = 4'h1;
    light_irq_enable = 1'b0;
    @(negedge clk);
    light_irq_enable = 1'b1;
    conv(4'hF);
    dat(FULL, FULL, FULL, FULL);
    cmp(20'(irq_pending), 20'h0, "first");
    conv(4'h0);
    dat(20'h0, 20'h0, 20'h0, 20'h0);
    conv(4'hF);
    cmp(20'(irq_pending), 20'h0, "restart");
    conv(4'hF);
    cmp(20'(irq_pending), 20'h1, "second");
    light_irq_enable = 1'b0;
    @(negedge clk);
    cmp(20'(irq_pending), 20'h0, "disabled");
    light_irq_enable = 1'b1;
    $display("test persist done");
  endtask

  task automatic t_variance();
    variance_trigger_select = 1'b1;
    irq_persist = 4'h0;
    conv(4'hF);
    cmp(20'(irq_pending), 20'h0, "no change");
    conv(4'h0);
    cmp(20'(irq_pending), 20'h1, "big change");
    $display("test variance done");
  endtask

  initial begin
    reset = 1'b1;
    light_measure_enable = 1'b0;
    color_sensing_mode = 1'b1;
    resolution_select = RES_13;
    light_irq_enable = 1'b1;
    variance_trigger_select = 1'b0;
    irq_source_channel = CH_RED;
    irq_persist = 4'h0;
    threshold_upper = 20'h00064;
    threshold_lower = 20'h00000;
    variance_threshold = 20'h01FFE;
    irq_clear = 1'b0;
    light_pulse = 4'h0;
    host_tx_byte = 8'h00;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_link();
    @(negedge clk);
    t_ambient();
    t_persist();
    t_variance();
    stop_test();
  end
endmodule
